/* File: hp_output_route_bank.v */
// Register bank for the left common-mode and right headphone output drivers.
// Assumes a byte-wide register port decoded by the serial control front end,
// one strobe per access on mclk, with address and data steady at that edge.
// Read data come back two edges after the read strobe and stand one cycle.
// The gain-pending flags come from the analog ramp logic and may change at
// any time, so they pass two flops here before anything reads them.
// Driver controls are levels for the analog side and hold until rewritten.
//
// Function
// - Each level field sits in bits 7..4 and codes 0..9 add that many dB of gain.
// - The powered-down drive bit gives weak common mode at 0, high impedance at 1, reset 1.
// - The read-only status bit reads 1 while programmed gains are pending, else 0.
// - The power bit fully powers the driver at 1 and resets to 0.
// - Six source registers route their source to the right driver via bit 7, reset 0.
// - Bits 6..0 of each source register hold a 7-bit volume, reset to zero.
// - The right driver has a level register identical in layout and reset to the left one.
`timescale 1ns/1ps
`include "hp_route_regs.vh"

module hp_output_route_bank
(
	input  wire        mclk,
	input  wire        rst_b,
	// Register port
	input  wire        reg_wr,
	input  wire        reg_rd,
	input  wire [7:0]  reg_addr,
	input  wire [7:0]  reg_wdata,
	output reg  [7:0]  reg_rdata,
	output reg         reg_hit,
	// Pending flags from the analog ramp logic, asynchronous
	input  wire        left_gain_pending,
	input  wire        right_gain_pending,
	// Left common-mode driver controls
	output reg  [3:0]  left_level_db,
	output reg         left_unmute,
	output reg         left_pd_hiz,
	output reg         left_power_up,
	// Right driver controls and source routing
	output reg  [3:0]  right_level_db,
	output reg         right_unmute,
	output reg         right_pd_hiz,
	output reg         right_power_up,
	output reg  [5:0]  right_route_en,
	output reg  [41:0] right_route_vol
);

	// ==========================================
	// Address decode helpers
	// Six source registers sit at consecutive offsets
	function is_source;
		input [7:0] a;
		begin
			is_source = (a >= `LINE2_LEFT_TO_RIGHT_HP_VOL) &&
			            (a <= `CONV_RIGHT_TO_RIGHT_HP_VOL);
		end
	endfunction

	// Index 0 is the first source register; only valid when is_source holds
	function [2:0] source_idx;
		input [7:0] a;
		reg [7:0] d;
		begin
			d = a - `LINE2_LEFT_TO_RIGHT_HP_VOL;
			source_idx = d[2:0];
		end
	endfunction

	// Level byte from stored fields with live status bit; the status bit
	// is never stored, it always shows the synchronised pending flag
	function [7:0] level_byte;
		input [6:0] held;
		input       busy;
		begin
			level_byte                            = 8'h00;
			level_byte[`LVL_GAIN_HI:`LVL_GAIN_LO] = held[6:3];
			level_byte[`LVL_UNMUTE_BIT]           = held[2];
			level_byte[`LVL_HIZ_BIT]              = held[1];
			level_byte[`LVL_BUSY_BIT]             = busy;
			level_byte[`LVL_POWER_BIT]            = held[0];
		end
	endfunction

	// Writable fields of a level byte, packed as {gain, unmute, hiz, power}
	function [6:0] held_fields;
		input [7:0] b;
		begin
			held_fields = {b[`LVL_GAIN_HI:`LVL_GAIN_LO],
			               b[`LVL_UNMUTE_BIT],
			               b[`LVL_HIZ_BIT],
			               b[`LVL_POWER_BIT]};
		end
	endfunction

	// ==========================================
	// Synchronised status (ramp logic may run off the analog clock)
	// Two flops per flag; nothing but the second flop is read, so a flag
	// seen mid-change can only shift the status by one edge, never split it.
	reg  [1:0]  left_busy_sync_reg;
	reg  [1:0]  right_busy_sync_reg;

	always @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			left_busy_sync_reg  <= 2'b00;
			right_busy_sync_reg <= 2'b00;
		end
		else
		begin
			left_busy_sync_reg  <= {left_busy_sync_reg[0], left_gain_pending};
			right_busy_sync_reg <= {right_busy_sync_reg[0], right_gain_pending};
		end
	end

	// Status as the register port sees it, two to three edges late
	wire left_busy  = left_busy_sync_reg[1];
	wire right_busy = right_busy_sync_reg[1];

	// ==========================================
	// Level registers: gain[6:3], unmute, hiz, power (status not stored)
	reg  [6:0]  left_lvl_reg;
	reg  [6:0]  right_lvl_reg;
	wire [6:0]  lvl_wr;

	// Reset pattern taken from the reset byte so both drivers agree
	localparam [7:0] lvl_rst_byte = `LVL_RESET;
	localparam [6:0] lvl_held_rst = {lvl_rst_byte[`LVL_GAIN_HI:`LVL_GAIN_LO],
	                                 lvl_rst_byte[`LVL_UNMUTE_BIT],
	                                 lvl_rst_byte[`LVL_HIZ_BIT],
	                                 lvl_rst_byte[`LVL_POWER_BIT]};

	// Status bit dropped on the way in, so a write can not fake a pending gain
	assign lvl_wr = held_fields(reg_wdata);

	// Left common-mode driver level register. Reserved level codes are
	// stored as written: keeping them out is the writer's duty, and a clamp
	// here would only hide the fault from software reading back.
	always @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
			left_lvl_reg <= lvl_held_rst;
		else if (reg_wr && (reg_addr == `LEFT_COMMON_DRIVER_LEVEL_CTRL))
			left_lvl_reg <= lvl_wr;
	end

	// Right driver level register, same layout and reset as the left one
	always @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
			right_lvl_reg <= lvl_held_rst;
		else if (reg_wr && (reg_addr == `RIGHT_HP_DRIVER_LEVEL_CTRL))
			right_lvl_reg <= lvl_wr;
	end

	// ==========================================
	// Source routing store
	wire [7:0]  src_rdata;
	wire [47:0] src_all;

	// Reads of other offsets use index 7, which the store answers with zero,
	// so its data can be merged without a second address compare.
	hp_source_store u_store
	(
		.mclk     (mclk),
		.rst_b    (rst_b),
		.wr_en    (reg_wr && is_source(reg_addr)),
		.wr_idx   (source_idx(reg_addr)),
		.wr_data  (reg_wdata),
		.rd_idx   (is_source(reg_addr) ? source_idx(reg_addr) : 3'd7),
		.rd_data  (src_rdata),
		.all_data (src_all)
	);

	// ==========================================
	// Read decode, delayed one edge to line up with the store's registered
	// data; the level bytes are assembled from live flops at that same edge,
	// so a read placed right after a write already returns the new value.
	reg         rd_src_reg;
	reg         rd_lvl_l_reg;
	reg         rd_lvl_r_reg;
	reg         rd_any_reg;

	always @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			rd_src_reg   <= 1'b0;
			rd_lvl_l_reg <= 1'b0;
			rd_lvl_r_reg <= 1'b0;
			rd_any_reg   <= 1'b0;
		end
		else
		begin
			rd_any_reg   <= reg_rd;
			rd_src_reg   <= reg_rd && is_source(reg_addr);
			rd_lvl_l_reg <= reg_rd && (reg_addr == `LEFT_COMMON_DRIVER_LEVEL_CTRL);
			rd_lvl_r_reg <= reg_rd && (reg_addr == `RIGHT_HP_DRIVER_LEVEL_CTRL);
		end
	end

	// ==========================================
	// Read data, registered one edge after the decode
	reg  [7:0]  rdata_next;
	integer     k;

	// Only one decode flag is set at a time; unmapped reads return zero
	always @*
	begin
		rdata_next = 8'h00;
		if (rd_src_reg)
			rdata_next = src_rdata;
		else if (rd_lvl_l_reg)
			rdata_next = level_byte(left_lvl_reg, left_busy);
		else if (rd_lvl_r_reg)
			rdata_next = level_byte(right_lvl_reg, right_busy);
	end

	// Read port flops; data and hit stand for exactly one cycle
	always @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			reg_rdata <= 8'h00;
			reg_hit   <= 1'b0;
		end
		else
		begin
			reg_rdata <= rdata_next;
			reg_hit   <= rd_any_reg && (rd_src_reg || rd_lvl_l_reg || rd_lvl_r_reg);
		end
	end

	// ==========================================
	// Driver control outputs
	// Each output is a flop copy of its register field, so the analog side
	// never sees a decode glitch; the price is one edge of delay after a
	// write, which is far below any audible settling time.

	// Left common-mode driver
	always @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			left_level_db <= lvl_held_rst[6:3];
			left_unmute   <= lvl_held_rst[2];
			left_pd_hiz   <= lvl_held_rst[1];
			left_power_up <= lvl_held_rst[0];
		end
		else
		begin
			left_level_db <= left_lvl_reg[6:3];
			left_unmute   <= left_lvl_reg[2];
			left_pd_hiz   <= left_lvl_reg[1];
			left_power_up <= left_lvl_reg[0];
		end
	end

	// Right driver; mirrors the left one field for field, so the two
	// channels of a stereo pair can not drift apart in behaviour
	always @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			right_level_db <= lvl_held_rst[6:3];
			right_unmute   <= lvl_held_rst[2];
			right_pd_hiz   <= lvl_held_rst[1];
			right_power_up <= lvl_held_rst[0];
		end
		else
		begin
			right_level_db <= right_lvl_reg[6:3];
			right_unmute   <= right_lvl_reg[2];
			right_pd_hiz   <= right_lvl_reg[1];
			right_power_up <= right_lvl_reg[0];
		end
	end

	// ==========================================
	// Source routing outputs
	// Enables and volumes go out as separate buses for the analog mixer.
	// The volume code is passed on untouched; its gain table lives with
	// the analog path, so no decoding happens here.
	always @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			right_route_en  <= 6'h00;
			right_route_vol <= 42'h0;
		end
		else
		begin
			for (k = 0; k < `SRC_COUNT; k = k + 1)
			begin
				right_route_en[k]         <= src_all[8*k + `SRC_ROUTE_BIT];
				right_route_vol[7*k +: 7] <= src_all[8*k + `SRC_VOL_LO +: 7];
			end
		end
	end

endmodule // hp_output_route_bank

/* File: hp_route_regs.vh */
// Register offsets, field positions and reset values for the headphone route bank.
// Included by the bank and its storage array; definitions only.
`ifndef HP_ROUTE_REGS_VH
`define HP_ROUTE_REGS_VH

// ==========================================
// Register offsets
`define LEFT_COMMON_DRIVER_LEVEL_CTRL 8'h3a
`define LINE2_LEFT_TO_RIGHT_HP_VOL    8'h3b
`define AMP_LEFT_TO_RIGHT_HP_VOL      8'h3c
`define CONV_LEFT_TO_RIGHT_HP_VOL     8'h3d
`define LINE2_RIGHT_TO_RIGHT_HP_VOL   8'h3e
`define AMP_RIGHT_TO_RIGHT_HP_VOL     8'h3f
`define CONV_RIGHT_TO_RIGHT_HP_VOL    8'h40
`define RIGHT_HP_DRIVER_LEVEL_CTRL    8'h41

// ==========================================
// Level register fields
`define LVL_GAIN_HI    7
`define LVL_GAIN_LO    4
`define LVL_UNMUTE_BIT 3
`define LVL_HIZ_BIT    2
`define LVL_BUSY_BIT   1
`define LVL_POWER_BIT  0
`define LVL_RESET      8'h04
`define LVL_GAIN_MAX   4'h9

// ==========================================
// Source routing register fields
`define SRC_ROUTE_BIT 7
`define SRC_VOL_HI    6
`define SRC_VOL_LO    0
`define SRC_RESET     8'h00
`define SRC_COUNT     6

`endif

/* File: hp_source_store.v */
// Six-entry store of source routing and volume bytes for the right driver.
// Assumes one write port and one read port on mclk; read data registered.
`timescale 1ns/1ps
`include "hp_route_regs.vh"

module hp_source_store
(
	input  wire       mclk,
	input  wire       rst_b,
	input  wire       wr_en,
	input  wire [2:0] wr_idx,
	input  wire [7:0] wr_data,
	input  wire [2:0] rd_idx,
	output reg  [7:0] rd_data,
	output wire [47:0] all_data
);

	reg [7:0] mem_reg [0:`SRC_COUNT-1];
	integer i;

	// ==========================================
	// Storage, reset to all zero
	always @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			for (i = 0; i < `SRC_COUNT; i = i + 1)
				mem_reg[i] <= `SRC_RESET;
			rd_data <= 8'h00;
		end
		else
		begin
			if (wr_en)
				mem_reg[wr_idx] <= wr_data;
			// Index beyond the table reads as zero
			rd_data <= (rd_idx < `SRC_COUNT) ? mem_reg[rd_idx] : 8'h00;
		end
	end

	// Flat view feeds the analog routing controls
	assign all_data = {mem_reg[5], mem_reg[4], mem_reg[3],
	                   mem_reg[2], mem_reg[1], mem_reg[0]};

endmodule // hp_source_store

/* File: hp_route_chk.sv */
// Assertions on the headphone route bank ports.
// Bound to hp_output_route_bank; sees its ports only.
`timescale 1ns/1ps
module hp_route_chk
(
	input logic        mclk,
	input logic        rst_b,
	input logic        reg_wr,
	input logic        reg_rd,
	input logic [7:0]  reg_addr,
	input logic [7:0]  reg_wdata,
	input logic [7:0]  reg_rdata,
	input logic        reg_hit,
	input logic        left_gain_pending,
	input logic        right_gain_pending,
	input logic [3:0]  left_level_db,
	input logic        left_unmute,
	input logic        left_pd_hiz,
	input logic        left_power_up,
	input logic [3:0]  right_level_db,
	input logic        right_unmute,
	input logic        right_pd_hiz,
	input logic        right_power_up,
	input logic [5:0]  right_route_en,
	input logic [41:0] right_route_vol
);
	// ==========
	// Write data two edges back
	logic [7:0] wd1_reg, wd2_reg;
	always @(posedge mclk)
	begin
		wd1_reg <= reg_wdata;
		wd2_reg <= wd1_reg;
	end
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_b);
	// Outputs may lag a write by one or two edges, so look after the second
	a_left_level: assert property (reg_wr && reg_addr == 8'h3a ##1 !reg_wr
		|=> left_level_db == wd2_reg[7:4]) else $error("left level wrong");
	a_left_ctrl: assert property (reg_wr && reg_addr == 8'h3a ##1 !reg_wr
		|=> {left_unmute, left_pd_hiz, left_power_up} == {wd2_reg[3:2], wd2_reg[0]})
		else $error("left control wrong");
	a_right_fields: assert property (reg_wr && reg_addr == 8'h41 ##1 !reg_wr
		|=> {right_level_db, right_unmute, right_pd_hiz, right_power_up}
		== {wd2_reg[7:2], wd2_reg[0]}) else $error("right fields wrong");
	a_route_first: assert property (reg_wr && reg_addr == 8'h3b ##1 !reg_wr
		|=> right_route_en[0] == wd2_reg[7]) else $error("route enable wrong");
	a_vol_last: assert property (reg_wr && reg_addr == 8'h40 ##1 !reg_wr
		|=> right_route_vol[41:35] == wd2_reg[6:0]) else $error("volume wrong");
	a_status_set: assert property (left_gain_pending [*4] ##0 (reg_rd && reg_addr == 8'h3a)
		|-> ##[1:3] (reg_hit && reg_rdata[1])) else $error("status not set");
	a_status_clear: assert property (!right_gain_pending [*4] ##0 (reg_rd && reg_addr == 8'h41)
		|-> ##[1:3] (reg_hit && !reg_rdata[1])) else $error("status not clear");
	a_reset_state: assert property ($rose(rst_b) |-> left_pd_hiz && right_pd_hiz
		&& !left_unmute && !right_power_up && right_route_en == 6'h00) else $error("reset wrong");
	cover property (reg_wr && reg_addr == 8'h41);
	cover property (reg_hit && reg_rdata[1]);
	cover property (reg_rd && reg_addr == 8'h42);
endmodule // hp_route_chk

bind hp_output_route_bank hp_route_chk u_chk (.*);

/* File: headphone_output_route_regs_tb.sv */
// Self-checking bench for the headphone route register bank.
// Drives the register port and pending flags directly; no far-side model.
`timescale 1ns/1ps
module headphone_output_route_regs_tb;
	logic        mclk = 0, rst_b = 0, reg_wr = 0, reg_rd = 0, reg_hit;
	logic        left_gain_pending = 0, right_gain_pending = 0;
	logic [7:0]  reg_addr = 0, reg_wdata = 0, reg_rdata, ra, rv;
	logic [3:0]  left_level_db, right_level_db;
	logic        left_unmute, left_pd_hiz, left_power_up;
	logic        right_unmute, right_pd_hiz, right_power_up;
	logic [5:0]  right_route_en, ee;
	logic [41:0] right_route_vol, ev;
	logic [7:0]  m [0:7];
	int          num_errors = 0, n_tests = 0, i, k;
	// ==========
	// Clock and device
	initial
	begin
		forever #50 mclk = ~mclk;
	end
	hp_output_route_bank dut (.*);
	// Compare and count
	task automatic chk(input string n, input logic [47:0] e, g);
		n_tests++;
		if (g !== e)
		begin
			num_errors++;
			$display("wrong value %s exp %h got %h", n, e, g);
		end
	endtask
	task automatic conclude;
		$display("checks %0d mismatches %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// Driver outputs against the model
	task automatic outs;
		for (k = 0; k < 6; k++)
		begin
			ee[k] = m[k + 1][7];
			ev[k * 7 +: 7] = m[k + 1][6:0];
		end
		chk("left", {m[0][7:2], m[0][0]}, {left_level_db, left_unmute, left_pd_hiz, left_power_up});
		chk("right", {m[7][7:2], m[7][0]}, {right_level_db, right_unmute, right_pd_hiz, right_power_up});
		chk("route", ee, right_route_en);
		chk("vol", ev, right_route_vol);
	endtask
	// One write; status bit never stored, unmapped writes dropped
	task automatic wr(input logic [7:0] a, d);
		@(posedge mclk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge mclk);
		reg_wr <= 1'b0;
		if (a >= 8'h3a && a <= 8'h41)
			m[a - 8'h3a] = (a == 8'h3a || a == 8'h41) ? (d & 8'hfd) : d;
		repeat (2) @(posedge mclk);
		outs();
	endtask
	// One read, answer polled for a bounded number of edges
	task automatic rd(input logic [7:0] a);
		logic [7:0] e;
		logic mp;
		mp = a >= 8'h3a && a <= 8'h41;
		e = mp ? m[a - 8'h3a] : 8'h00;
		if (a == 8'h3a)
			e[1] = left_gain_pending;
		if (a == 8'h41)
			e[1] = right_gain_pending;
		@(posedge mclk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge mclk);
		reg_rd <= 1'b0;
		for (k = 0; k < 4 && reg_hit !== 1'b1; k++)
			@(posedge mclk);
		chk("hit", mp, reg_hit);
		chk("rdata", e, reg_rdata);
		if (reg_hit !== mp)
			conclude();
	endtask
	// ==========
	// Main sequence
	initial
	begin
		void'($urandom(32'he9f8));
		for (k = 0; k < 8; k++)
			m[k] = (k == 0 || k == 7) ? 8'h04 : 8'h00;
		repeat (10) @(posedge mclk);
		rst_b <= 1'b1;
		outs();
		for (i = 8'h3a; i <= 8'h42; i++)
			rd(i[7:0]);
		$display("reset test done");
		left_gain_pending <= 1'b1;
		for (i = 0; i < 10; i++)
		begin
			wr(8'h3a, {i[3:0], 4'hf});
			wr(8'h41, {4'(9 - i), 4'ha});
			rd(8'h3a);
			rd(8'h41);
		end
		wr(8'h39, 8'hff);
		$display("level test done");
		for (i = 0; i < 30; i++)
		begin
			ra = 8'h3a + 8'($urandom % 9);
			rv = 8'($urandom);
			if ((ra == 8'h3a || ra == 8'h41) && rv[7:4] > 4'h9)
				rv[7:4] = 4'($urandom % 10);
			left_gain_pending <= 1'($urandom);
			right_gain_pending <= 1'($urandom);
			wr(ra, rv);
			rd(ra);
		end
		$display("random test done");
		conclude();
	end
endmodule // headphone_output_route_regs_tb
